// >>> rtl/scg_guard.sv
// Clock source guard with PLL slip response
//
// Operation
// - Disable request for a source in use, oscillator under PLL included, is ignored.
// - Loss of oscillator feeding the PLL is handled exactly as a slip.
// - A slip sets the lock-loss flag, bit 8 of global status.
// - A slip moves source 1 off the PLL if enabled; PLL blocked.
// - A slip raises an error-collector event when reporting is enabled.
// - A slip issues device reset when reset-on-slip control bit is set.
// - PLL clock never reaches domains while the lock-loss flag is set.
// - After oscillator restart, no PLL clock until oscillator then PLL stabilise.
`timescale 1ns/1ps
module scg_guard #(
   parameter int unsigned OSC_CYC = scg_pkg::OSC_START_CYC,
   parameter int unsigned PLL_CYC = scg_pkg::PLL_LOCK_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Source enable requests
   input wire logic src_dis_req,
   input wire logic src_en_req,
   input wire logic [2:0] src_idx,
   // Domain source selects, one per domain
   input wire logic dom_sel_we,
   input wire logic [2:0] dom_sel_d0,
   input wire logic [2:0] dom_sel_d1,
   // Slip detection
   input wire logic pll_slip,
   input wire logic osc_lost,
   // Controls
   input wire logic slip_switch_en,
   input wire logic slip_err_en,
   input wire logic slip_reset_en,
   input wire logic flag_clr_we,
   input wire logic [15:0] flag_clr_data,
   // Outputs
   output logic [7:0] src_en,
   output logic [2:0] dom_sel0,
   output logic [2:0] dom_sel1,
   output logic pll_gate,
   output logic [15:0] global_clock_status_reg,
   output logic err_event,
   output logic dev_reset
);
   logic [7:0] en_q, en_d;
   logic [2:0] s0_q, s0_d, s1_q, s1_d;
   logic flag_q, flag_d, err_q, err_d, rstout_q, rstout_d, gate_q, gate_d;
   scg_pkg::scg_pll_state_t st_q, st_d;
   logic [scg_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0] in_use;
   logic slip;

   always_comb begin
      in_use = 8'h00;
      in_use[s0_q] = 1'b1;
      in_use[s1_q] = 1'b1;
      // Oscillator counts as used whenever the PLL is enabled
      if (en_q[scg_pkg::PLL_SRC]) begin
         in_use[scg_pkg::OSC_SRC] = 1'b1;
      end
   end

   assign slip = pll_slip | (osc_lost & en_q[scg_pkg::PLL_SRC]);

   always_comb begin
      en_d = en_q;
      s0_d = s0_q;
      s1_d = s1_q;
      flag_d = flag_q;
      err_d = 1'b0;
      rstout_d = 1'b0;
      st_d = st_q;
      cnt_d = cnt_q;
      if (src_en_req) begin
         en_d[src_idx] = 1'b1;
      end else if (src_dis_req && !in_use[src_idx]) begin
         en_d[src_idx] = 1'b0;
      end
      if (dom_sel_we) begin
         s0_d = dom_sel_d0;
         s1_d = dom_sel_d1;
      end
      if (flag_clr_we && flag_clr_data[scg_pkg::LOCK_LOSS_BIT]) begin
         flag_d = 1'b0;
      end
      if (slip) begin
         flag_d = 1'b1;
         err_d = slip_err_en;
         rstout_d = slip_reset_en;
         if (slip_switch_en && s1_d == 3'(scg_pkg::PLL_SRC)) begin
            s1_d = 3'(scg_pkg::OSC_SRC);
         end
         st_d = scg_pkg::SCG_PLL_OFF;
      end else begin
         unique case (st_q)
            scg_pkg::SCG_PLL_OFF: begin
               if (en_q[scg_pkg::PLL_SRC] && en_q[scg_pkg::OSC_SRC]) begin
                  st_d = scg_pkg::SCG_OSC_WAIT;
                  cnt_d = scg_pkg::CNT_W'(OSC_CYC - 1);
               end
            end
            scg_pkg::SCG_OSC_WAIT: begin
               if (cnt_q == '0) begin
                  st_d = scg_pkg::SCG_PLL_WAIT;
                  cnt_d = scg_pkg::CNT_W'(PLL_CYC - 1);
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            scg_pkg::SCG_PLL_WAIT: begin
               if (cnt_q == '0) begin
                  st_d = scg_pkg::SCG_PLL_OK;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            scg_pkg::SCG_PLL_OK: begin
               if (!en_q[scg_pkg::PLL_SRC] || !en_q[scg_pkg::OSC_SRC]) begin
                  st_d = scg_pkg::SCG_PLL_OFF;
               end
            end
         endcase
         if (!en_d[scg_pkg::PLL_SRC] || !en_d[scg_pkg::OSC_SRC]) begin
            st_d = scg_pkg::SCG_PLL_OFF;
         end
      end
      // Gate follows next-state flag and lock state; a slip closes it on the same edge that sets the flag
      gate_d = (st_d == scg_pkg::SCG_PLL_OK) && !flag_d;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_q <= scg_pkg::SRC_EN_RST;
         s0_q <= scg_pkg::DOM_SEL_RST;
         s1_q <= scg_pkg::DOM_SEL_RST;
         flag_q <= 1'b0;
         err_q <= 1'b0;
         rstout_q <= 1'b0;
         gate_q <= 1'b0;
         st_q <= scg_pkg::SCG_PLL_OFF;
         cnt_q <= '0;
      end else begin
         en_q <= en_d;
         s0_q <= s0_d;
         s1_q <= s1_d;
         flag_q <= flag_d;
         err_q <= err_d;
         rstout_q <= rstout_d;
         gate_q <= gate_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign src_en = en_q;
   assign dom_sel0 = s0_q;
   assign dom_sel1 = s1_q;
   assign pll_gate = gate_q;
   assign err_event = err_q;
   assign dev_reset = rstout_q;
   always_comb begin
      global_clock_status_reg = 16'h0000;
      global_clock_status_reg[scg_pkg::LOCK_LOSS_BIT] = flag_q;
   end

   // Checks
   property p_no_osc_off_with_pll;
      @(posedge clk_sys) disable iff (rst)
      $past(en_q[scg_pkg::PLL_SRC]) && en_q[scg_pkg::PLL_SRC] |-> en_q[scg_pkg::OSC_SRC];
   endproperty
   a_no_osc_off_with_pll: assert property (p_no_osc_off_with_pll)
      else $error("oscillator disabled under PLL");
   property p_used_kept;
      @(posedge clk_sys) disable iff (rst)
      src_dis_req && !src_en_req && in_use[src_idx] |=>
         en_q[$past(src_idx)] == $past(en_q[src_idx]);
   endproperty
   a_used_kept: assert property (p_used_kept)
      else $error("used source disabled");
   property p_osc_loss_slip;
      @(posedge clk_sys) disable iff (rst)
      osc_lost && en_q[scg_pkg::PLL_SRC] |=> flag_q && !pll_gate;
   endproperty
   a_osc_loss_slip: assert property (p_osc_loss_slip)
      else $error("osc loss not treated as slip");
   property p_flag_set;
      @(posedge clk_sys) disable iff (rst)
      slip |=> global_clock_status_reg[scg_pkg::LOCK_LOSS_BIT];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("lock-loss flag not set");
   property p_switch;
      @(posedge clk_sys) disable iff (rst)
      // Switch also overrides a same-cycle select write of the PLL
      slip && slip_switch_en |=> dom_sel1 != 3'(scg_pkg::PLL_SRC);
   endproperty
   a_switch: assert property (p_switch)
      else $error("source 1 left on PLL");
   property p_err;
      @(posedge clk_sys) disable iff (rst)
      slip |=> err_event == $past(slip_err_en);
   endproperty
   a_err: assert property (p_err)
      else $error("error event wrong");
   property p_reset;
      @(posedge clk_sys) disable iff (rst)
      slip |=> dev_reset == $past(slip_reset_en);
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset on slip wrong");
   property p_gate_flag;
      @(posedge clk_sys) disable iff (rst)
      flag_q |-> !pll_gate;
   endproperty
   a_gate_flag: assert property (p_gate_flag)
      else $error("PLL passed with flag set");
   property p_gate_lock;
      @(posedge clk_sys) disable iff (rst)
      pll_gate |-> st_q == scg_pkg::SCG_PLL_OK;
   endproperty
   a_gate_lock: assert property (p_gate_lock)
      else $error("PLL passed before stable");
   property p_clear_one;
      @(posedge clk_sys) disable iff (rst)
      flag_q && !slip && !(flag_clr_we && flag_clr_data[scg_pkg::LOCK_LOSS_BIT]) |=> flag_q;
   endproperty
   a_clear_one: assert property (p_clear_one)
      else $error("flag cleared without write of one");
   c_slip: cover property (@(posedge clk_sys) disable iff (rst) slip ##1 flag_q);
   c_gate: cover property (@(posedge clk_sys) disable iff (rst) $rose(pll_gate));
   c_reset: cover property (@(posedge clk_sys) disable iff (rst) dev_reset);
   c_ignored: cover property (@(posedge clk_sys) disable iff (rst)
      src_dis_req && in_use[src_idx]);
endmodule

// >>> rtl/scg_pkg.sv
// Package of constants and types for the clock source guard
package scg_pkg;
   // Status bit positions
   localparam int unsigned LOCK_LOSS_BIT = 8;
   localparam int unsigned STATUS_W = 16;
   // Source numbering
   localparam int unsigned NUM_SRC = 8;
   localparam int unsigned OSC_SRC = 0;
   localparam int unsigned PLL_SRC = 1;
   // Restart times, in microseconds
   localparam int unsigned OSC_START_US = 2000;
   localparam int unsigned PLL_LOCK_US = 1000;
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned OSC_START_CYC = OSC_START_US * CLK_MHZ;
   localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
   localparam int unsigned CNT_W = 20;
   // Reset values
   localparam logic [7:0] SRC_EN_RST = 8'h03;
   localparam logic [2:0] DOM_SEL_RST = 3'h0;
   // PLL restart states
   typedef enum logic [1:0] {
      SCG_PLL_OFF = 2'b00,
      SCG_OSC_WAIT = 2'b01,
      SCG_PLL_WAIT = 2'b11,
      SCG_PLL_OK = 2'b10
   } scg_pll_state_t;
endpackage

// >>> dv/scg_guard_tb.sv
// Self-checking testbench for the clock source guard
`timescale 1ns/1ps
module scg_guard_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic src_dis_req = 1'b0;
   logic src_en_req = 1'b0;
   logic dom_sel_we = 1'b0;
   logic pll_slip = 1'b0;
   logic osc_lost = 1'b0;
   logic slip_switch_en = 1'b0;
   logic slip_err_en = 1'b0;
   logic slip_reset_en = 1'b0;
   logic flag_clr_we = 1'b0;
   logic [2:0] src_idx = 3'h0;
   logic [2:0] dom_sel_d0 = 3'h0;
   logic [2:0] dom_sel_d1 = 3'h0;
   logic [15:0] flag_clr_data = 16'h0000;
   logic [7:0] src_en;
   logic [2:0] dom_sel0;
   logic [2:0] dom_sel1;
   logic [15:0] status;
   logic pll_gate;
   logic err_event;
   logic dev_reset;
   logic [7:0] exp_en;
   logic [31:0] seed = 32'h3ECC48C3;
   logic [2:0] k;
   int compares = 0;
   int miscompares = 0;
   int cycles = 0;

   // Short restart counts keep the run brief
   scg_guard #(.OSC_CYC(4), .PLL_CYC(3)) DUT (.clk_sys(clk_sys), .rst(rst),
      .src_dis_req(src_dis_req), .src_en_req(src_en_req), .src_idx(src_idx),
      .dom_sel_we(dom_sel_we), .dom_sel_d0(dom_sel_d0), .dom_sel_d1(dom_sel_d1),
      .pll_slip(pll_slip), .osc_lost(osc_lost), .slip_switch_en(slip_switch_en),
      .slip_err_en(slip_err_en), .slip_reset_en(slip_reset_en),
      .flag_clr_we(flag_clr_we), .flag_clr_data(flag_clr_data), .src_en(src_en),
      .dom_sel0(dom_sel0), .dom_sel1(dom_sel1), .pll_gate(pll_gate),
      .global_clock_status_reg(status), .err_event(err_event), .dev_reset(dev_reset));

   always #20 clk_sys = ~clk_sys;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Restart time is bounded, so a gate that never opens is caught
   task automatic wait_gate;
      for (int i = 0; i < 20 && pll_gate !== 1'b1; i++) cyc(1);
      chk("pll_gate", 16'h0001, 16'(pll_gate));
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      cyc(8);
      rst = 1'b0;
      chk("src_en", 16'h0003, 16'(src_en));
      chk("status", 16'h0000, status);
      cyc(5);
      chk("pll_gate", 16'h0000, 16'(pll_gate));
      wait_gate();
      dom_sel_we = 1'b1;
      dom_sel_d0 = 3'h1;
      dom_sel_d1 = 3'h1;
      cyc(1);
      dom_sel_we = 1'b0;
      chk("dom_sel0", 16'h0001, 16'(dom_sel0));
      chk("dom_sel1", 16'h0001, 16'(dom_sel1));
      src_dis_req = 1'b1;
      cyc(1);
      chk("src_en", 16'h0003, 16'(src_en));
      src_idx = 3'h1;
      cyc(1);
      src_dis_req = 1'b0;
      chk("src_en", 16'h0003, 16'(src_en));
      exp_en = 8'h03;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr_next(seed);
         k = 3'(2 + seed % 6);
         src_idx = k;
         src_en_req = 1'b1;
         cyc(1);
         src_en_req = 1'b0;
         src_dis_req = 1'b1;
         exp_en[k] = 1'b1;
         chk("src_en", 16'(exp_en), 16'(src_en));
         cyc(1);
         src_dis_req = 1'b0;
         exp_en[k] = 1'b0;
         chk("src_en", 16'(exp_en), 16'(src_en));
      end
      slip_switch_en = 1'b1;
      slip_err_en = 1'b1;
      slip_reset_en = 1'b1;
      pll_slip = 1'b1;
      cyc(1);
      pll_slip = 1'b0;
      chk("status", 16'h0100, status);
      chk("err_event", 16'h0001, 16'(err_event));
      chk("dev_reset", 16'h0001, 16'(dev_reset));
      chk("dom_sel1", 16'h0000, 16'(dom_sel1));
      chk("pll_gate", 16'h0000, 16'(pll_gate));
      cyc(1);
      chk("err_event", 16'h0000, 16'(err_event));
      chk("dev_reset", 16'h0000, 16'(dev_reset));
      cyc(12);
      chk("pll_gate", 16'h0000, 16'(pll_gate));
      seed = lfsr_next(seed);
      flag_clr_we = 1'b1;
      flag_clr_data = seed[15:0] & 16'hFEFF;
      cyc(1);
      chk("status", 16'h0100, status);
      flag_clr_data = 16'h0100;
      cyc(1);
      flag_clr_we = 1'b0;
      chk("status", 16'h0000, status);
      wait_gate();
      slip_switch_en = 1'b0;
      slip_err_en = 1'b0;
      slip_reset_en = 1'b0;
      dom_sel_we = 1'b1;
      cyc(1);
      dom_sel_we = 1'b0;
      // Slip must win over a same-cycle clear
      osc_lost = 1'b1;
      flag_clr_we = 1'b1;
      cyc(1);
      osc_lost = 1'b0;
      flag_clr_we = 1'b0;
      chk("status", 16'h0100, status);
      chk("pll_gate", 16'h0000, 16'(pll_gate));
      chk("err_event", 16'h0000, 16'(err_event));
      chk("dev_reset", 16'h0000, 16'(dev_reset));
      chk("dom_sel1", 16'h0001, 16'(dom_sel1));
      // Proper shutdown order: PLL first, then its oscillator
      dom_sel_we = 1'b1;
      dom_sel_d0 = 3'h2;
      dom_sel_d1 = 3'h2;
      cyc(1);
      dom_sel_we = 1'b0;
      chk("dom_sel0", 16'h0002, 16'(dom_sel0));
      src_idx = 3'h1;
      src_dis_req = 1'b1;
      cyc(1);
      chk("src_en", 16'h0001, 16'(src_en));
      src_idx = 3'h0;
      cyc(1);
      src_dis_req = 1'b0;
      chk("src_en", 16'h0000, 16'(src_en));
      // Restart from a stopped oscillator with the flag cleared
      src_en_req = 1'b1;
      flag_clr_we = 1'b1;
      cyc(1);
      src_idx = 3'h1;
      cyc(1);
      src_en_req = 1'b0;
      flag_clr_we = 1'b0;
      chk("src_en", 16'h0003, 16'(src_en));
      chk("status", 16'h0000, status);
      cyc(5);
      chk("pll_gate", 16'h0000, 16'(pll_gate));
      wait_gate();
      complete_run();
   end
endmodule
